// >>> rtl/nco_ctrl_top.sv
/*
  Oscillator tuning and phase control bank: APB register slave,
  shadowed tuning word, strobe-armed oscillator reset, interrupts.
  Assumes one clock, an APB master with 32-bit data and a frame
  strobe input synchronous to i_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module nco_ctrl_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_frame_strobe,
  output logic [31:0] o_tuning_word,
  output logic [15:0] o_carrier_phase,
  output logic [15:0] o_i_phase,
  output logic [15:0] o_q_phase,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // State and decode.
  // ---------------------------------------------------------------

  nco_pkg::nco_regs_type st_q;
  nco_pkg::nco_regs_type st_d;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic acc_edge;
  logic wr_en;
  logic ctrl_wr;
  logic load_rise;
  logic strb_rise;
  logic ext_pulse;

  // Bus phase decode: writes land at the edge that samples pready.
  // Writes to unmapped or aliased addresses are dropped.
  assign idx = nco_pkg::nco_reg_index(i_paddr);
  assign wbyte = i_pwdata[7:0];
  assign acc_edge = i_psel & i_penable & st_q.pready;
  assign wr_en = acc_edge & i_pwrite & nco_pkg::nco_is_mapped(i_paddr);
  assign ctrl_wr = wr_en & (idx == nco_pkg::NCO_IDX_CTRL);
  assign load_rise = ctrl_wr & wbyte[nco_pkg::NCO_LOAD_REQ_BIT] &
    ~st_q.load_req;
  assign strb_rise = ctrl_wr & wbyte[nco_pkg::NCO_STRB_REQ_BIT] &
    ~st_q.strb_req;

  // Byte seen by software at a register index.
  function automatic logic [7:0] read_byte(
    input logic [7:0] i,
    input nco_pkg::nco_regs_type s
  );
    logic [7:0] v;
    v = 8'h00;
    if (i == nco_pkg::NCO_IDX_TW0) begin
      v = s.tw_shadow[7:0];
    end else if (i == nco_pkg::NCO_IDX_TW1) begin
      v = s.tw_shadow[15:8];
    end else if (i == nco_pkg::NCO_IDX_TW2) begin
      v = s.tw_shadow[23:16];
    end else if (i == nco_pkg::NCO_IDX_TW3) begin
      v = s.tw_shadow[31:24];
    end else if (i == nco_pkg::NCO_IDX_PH_LO) begin
      v = s.start_phase[7:0];
    end else if (i == nco_pkg::NCO_IDX_PH_HI) begin
      v = s.start_phase[15:8];
    end else if (i == nco_pkg::NCO_IDX_CTRL) begin
      v[nco_pkg::NCO_LOAD_REQ_BIT] = s.load_req;
      v[nco_pkg::NCO_LOAD_ACK_BIT] = s.load_ack;
      v[nco_pkg::NCO_STRB_REQ_BIT] = s.strb_req;
      v[nco_pkg::NCO_STRB_ACK_BIT] = s.strb_ack;
    end else if (i == nco_pkg::NCO_IDX_ITRIM_LO) begin
      v = s.i_trim[7:0];
    end else if (i == nco_pkg::NCO_IDX_ITRIM_HI) begin
      v[1:0] = s.i_trim[9:8];
    end else if (i == nco_pkg::NCO_IDX_QTRIM_LO) begin
      v = s.q_trim[7:0];
    end else if (i == nco_pkg::NCO_IDX_QTRIM_HI) begin
      v[1:0] = s.q_trim[9:8];
    end else if (i == nco_pkg::NCO_IDX_STAT) begin
      v[1:0] = s.irq_stat;
    end else if (i == nco_pkg::NCO_IDX_MASK) begin
      v[1:0] = s.irq_mask;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------

  // Bus answer, register writes, handoff events and interrupt level.
  always_comb begin
    st_d = st_q;
    st_d.osc_rst = 1'b0;

    // One wait state: pready rises in the second access cycle.
    st_d.pready = i_psel & i_penable & ~st_q.pready;
    st_d.pslverr = 1'b0;
    if (st_d.pready) begin
      st_d.prdata = 32'h0000_0000;
      st_d.pslverr = ~nco_pkg::nco_is_mapped(i_paddr);
      // An unmapped address reads zero, aliases included.
      if (!st_d.pslverr) begin
        st_d.prdata = {24'h00_0000, read_byte(idx, st_q)};
      end
    end

    // Plain byte stores; none of them touches the running carrier.
    if (wr_en) begin
      if (idx == nco_pkg::NCO_IDX_TW0) begin
        st_d.tw_shadow[7:0] = wbyte; // [R1] [R2]
      end else if (idx == nco_pkg::NCO_IDX_TW1) begin
        st_d.tw_shadow[15:8] = wbyte; // [R1]
      end else if (idx == nco_pkg::NCO_IDX_TW2) begin
        st_d.tw_shadow[23:16] = wbyte; // [R1]
      end else if (idx == nco_pkg::NCO_IDX_TW3) begin
        st_d.tw_shadow[31:24] = wbyte; // [R1]
      end else if (idx == nco_pkg::NCO_IDX_PH_LO) begin
        st_d.start_phase[7:0] = wbyte; // [R4]
      end else if (idx == nco_pkg::NCO_IDX_PH_HI) begin
        st_d.start_phase[15:8] = wbyte; // [R4]
      end else if (idx == nco_pkg::NCO_IDX_CTRL) begin
        st_d.load_req = wbyte[nco_pkg::NCO_LOAD_REQ_BIT];
        st_d.strb_req = wbyte[nco_pkg::NCO_STRB_REQ_BIT];
        // Writing a request to 0 drops its acknowledge and re-arms.
        if (!wbyte[nco_pkg::NCO_LOAD_REQ_BIT]) begin
          st_d.load_ack = 1'b0; // [R13]
        end
        if (!wbyte[nco_pkg::NCO_STRB_REQ_BIT]) begin
          st_d.strb_ack = 1'b0; // [R13]
          st_d.strb_pend = 1'b0;
        end
      end else if (idx == nco_pkg::NCO_IDX_ITRIM_LO) begin
        st_d.i_trim[7:0] = wbyte; // [R9]
      end else if (idx == nco_pkg::NCO_IDX_ITRIM_HI) begin
        st_d.i_trim[9:8] = wbyte[1:0]; // [R9]
      end else if (idx == nco_pkg::NCO_IDX_QTRIM_LO) begin
        st_d.q_trim[7:0] = wbyte; // [R10]
      end else if (idx == nco_pkg::NCO_IDX_QTRIM_HI) begin
        st_d.q_trim[9:8] = wbyte[1:0]; // [R10]
      end else if (idx == nco_pkg::NCO_IDX_STAT) begin
        st_d.irq_stat = st_q.irq_stat & ~wbyte[1:0];
      end else if (idx == nco_pkg::NCO_IDX_MASK) begin
        st_d.irq_mask = wbyte[1:0];
      end
    end

    // Rising load request moves the whole shadow word at once.
    // Software has written all four bytes beforehand. [R11]
    if (load_rise) begin
      st_d.tw_active = st_q.tw_shadow; // [R2]
      st_d.load_ack = 1'b1; // [R3]
      st_d.irq_stat[nco_pkg::NCO_IRQ_LOAD_BIT] = 1'b1;
    end

    // Rising strobe request arms the reset for the next long frame.
    if (strb_rise) begin
      st_d.strb_pend = 1'b1; // [R7]
    end

    // Armed reset fires on a long frame; set wins over any clear.
    if (ext_pulse && st_q.strb_pend) begin
      st_d.osc_rst = 1'b1; // [R7]
      st_d.strb_pend = 1'b0;
      st_d.strb_ack = 1'b1; // [R8]
      st_d.irq_stat[nco_pkg::NCO_IRQ_STRB_BIT] = 1'b1;
    end

    // Level interrupt from unmasked sticky bits.
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  // ---------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------

  // All control state clears on reset, the tuning word included.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
      st_q.tw_shadow <= nco_pkg::NCO_TW_RST; // [R1]
      st_q.tw_active <= nco_pkg::NCO_TW_RST;
      st_q.start_phase <= nco_pkg::NCO_PHASE_RST;
      st_q.i_trim <= nco_pkg::NCO_TRIM_RST;
      st_q.q_trim <= nco_pkg::NCO_TRIM_RST;
      st_q.irq_stat <= nco_pkg::NCO_IRQ_RST;
      st_q.irq_mask <= nco_pkg::NCO_IRQ_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame strobe and oscillator.
  // ---------------------------------------------------------------

  nco_frame_strobe u_frame (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_frame(i_frame_strobe),
    .o_ext_pulse(ext_pulse)
  );

  nco_phase_gen u_phase (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tw(st_q.tw_active),
    .i_start(st_q.start_phase),
    .i_load(st_q.osc_rst),
    .i_i_trim(st_q.i_trim),
    .i_q_trim(st_q.q_trim),
    .o_phase(o_carrier_phase),
    .o_i_phase(o_i_phase),
    .o_q_phase(o_q_phase)
  );

  // Outputs straight from the state register.
  assign o_prdata = st_q.prdata;
  assign o_pready = st_q.pready;
  assign o_pslverr = st_q.pslverr;
  assign o_tuning_word = st_q.tw_active;
  assign o_irq = st_q.irq;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_arm;
    strb_rise ##1 st_q.strb_pend;
  endsequence

  sequence s_fire;
    st_q.strb_pend && ext_pulse;
  endsequence

  sequence s_reset_done;
    st_q.osc_rst && st_q.strb_ack ##1 !st_q.osc_rst;
  endsequence

  AST_TW_BYTE3: assert property ( // [R1]
    wr_en && idx == nco_pkg::NCO_IDX_TW3
    |=> st_q.tw_shadow[31:24] == $past(wbyte))
    else $error("Tuning byte 3 not stored.");

  AST_TW_HELD: assert property ( // [R2]
    !load_rise |=> $stable(st_q.tw_active))
    else $error("Active tuning word changed without a load.");

  AST_TW_LOAD: assert property ( // [R2]
    load_rise |=> st_q.tw_active == $past(st_q.tw_shadow))
    else $error("Active word not loaded from the shadow.");

  AST_LOAD_ACK: assert property ( // [R3]
    load_rise |=> st_q.load_ack && st_q.irq_stat[0])
    else $error("Load acknowledge not set.");

  AST_ARM: assert property ( // [R7]
    strb_rise |-> s_arm)
    else $error("Strobe request did not arm.");

  AST_STRB_FIRE: assert property ( // [R7] [R8]
    s_fire |=> s_reset_done)
    else $error("Armed frame did not reset the oscillator.");

  AST_NO_STRAY_RESET: assert property ( // [R7]
    !(st_q.strb_pend && ext_pulse) |=> !st_q.osc_rst)
    else $error("Oscillator reset without an armed frame.");

  AST_ACK_HOLD: assert property ( // [R13]
    st_q.load_ack && !(ctrl_wr && !wbyte[0]) |=> st_q.load_ack)
    else $error("Load acknowledge dropped early.");

  AST_APB_WAIT: assert property (
    i_psel && i_penable && !o_pready |=> o_pready)
    else $error("Bus answer later than one wait state.");

  AST_IRQ_LEVEL: assert property (
    ##1 o_irq == |(st_q.irq_stat & st_q.irq_mask))
    else $error("Interrupt level disagrees with status.");

  // ---------------------------------------------------------------
  // Register store, re-arm and error checks.
  // ---------------------------------------------------------------

  AST_TW_BYTE0: assert property ( // [R1]
    wr_en && idx == nco_pkg::NCO_IDX_TW0
    |=> st_q.tw_shadow[7:0] == $past(wbyte))
    else $error("Tuning byte 0 not stored.");

  AST_PHASE_HI: assert property ( // [R4]
    wr_en && idx == nco_pkg::NCO_IDX_PH_HI
    |=> st_q.start_phase[15:8] == $past(wbyte))
    else $error("Start phase high byte not stored.");

  AST_ITRIM_HI: assert property ( // [R9]
    wr_en && idx == nco_pkg::NCO_IDX_ITRIM_HI
    |=> st_q.i_trim[9:8] == $past(wbyte[1:0]))
    else $error("I trim top bits not stored.");

  AST_QTRIM_HI: assert property ( // [R10]
    wr_en && idx == nco_pkg::NCO_IDX_QTRIM_HI
    |=> st_q.q_trim[9:8] == $past(wbyte[1:0]))
    else $error("Q trim top bits not stored.");

  AST_STRB_ACK_HOLD: assert property ( // [R13]
    st_q.strb_ack && !(ctrl_wr && !wbyte[4]) |=> st_q.strb_ack)
    else $error("Strobe acknowledge dropped early.");

  AST_STRB_CLR: assert property ( // [R13]
    ctrl_wr && !wbyte[4] && !(st_q.strb_pend && ext_pulse)
    |=> !st_q.strb_ack && !st_q.strb_pend)
    else $error("Strobe request clear did not re-arm.");

  AST_LOAD_CLR: assert property ( // [R13]
    ctrl_wr && !wbyte[0] |=> !st_q.load_ack)
    else $error("Load request clear did not drop the acknowledge.");

  AST_STRB_STATUS: assert property ( // [R8]
    s_fire |=> st_q.irq_stat[1])
    else $error("Strobe reset did not set its status bit.");

  AST_UNMAPPED_ERR: assert property (
    i_psel && i_penable && !o_pready &&
    !nco_pkg::nco_is_mapped(i_paddr) |=> o_pready && o_pslverr)
    else $error("Unmapped access answered without an error.");

  AST_UNMAPPED_WR: assert property (
    acc_edge && !nco_pkg::nco_is_mapped(i_paddr)
    |=> $stable(st_q.tw_shadow) && $stable(st_q.start_phase))
    else $error("Unmapped write changed a register.");

endmodule // nco_ctrl_top

`default_nettype wire

// >>> rtl/nco_frame_strobe.sv
/*
  Extended frame strobe detector: one pulse when the frame input has
  been high for a set number of consecutive cycles.
  Assumes the frame input is synchronous to i_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module nco_frame_strobe (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_frame,
  output logic o_ext_pulse
);

  typedef struct packed {
    logic [3:0] cnt;
    logic fired;
    logic pulse;
  } nco_strb_type;

  nco_strb_type st_q;
  nco_strb_type st_d;

  // Counts the high time and fires once per long frame high.
  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    if (!i_frame) begin
      st_d.cnt = 4'h0;
      st_d.fired = 1'b0;
    end else if (!st_q.fired) begin
      st_d.cnt = st_q.cnt + 4'h1;
      if (st_d.cnt == nco_pkg::NCO_FRAME_EXT_CYCLES) begin
        st_d.pulse = 1'b1; // [R7]
        st_d.fired = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_ext_pulse = st_q.pulse;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // A pulse needs the frame high at the first and last cycle of the qualifying time.
  AST_EXT_PULSE: assert property ( // [R7]
    o_ext_pulse |-> $past(i_frame, 1) && $past(i_frame, 4))
    else $error("Frame pulse without a long frame high.");

endmodule // nco_frame_strobe

`default_nettype wire

// >>> rtl/nco_phase_gen.sv
/*
  Phase accumulator with start-phase load and I/Q phase trims.
  Assumes the load pulse and all words come from flip-flops.
*/
`timescale 1ns/100ps
`default_nettype none

module nco_phase_gen (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_tw,
  input wire logic [15:0] i_start,
  input wire logic i_load,
  input wire logic [9:0] i_i_trim,
  input wire logic [9:0] i_q_trim,
  output logic [15:0] o_phase,
  output logic [15:0] o_i_phase,
  output logic [15:0] o_q_phase
);

  typedef struct packed {
    logic [31:0] acc;
    logic [1:0][15:0] path;
  } nco_acc_type;

  nco_acc_type st_q;
  nco_acc_type st_d;
  logic [1:0][9:0] trim;

  // Path 0 carries the I trim and path 1 the Q trim.
  assign trim = {i_q_trim, i_i_trim};

  // Steps the accumulator and offsets each path by its signed trim.
  always_comb begin
    st_d = st_q;
    if (i_load) begin
      // Signed start word as a turn fraction; -x lands on 360 - x.
      st_d.acc = {i_start, 16'h0000}; // [R4] [R5] [R6]
    end else begin
      st_d.acc = st_q.acc + i_tw; // [R12]
    end
    for (int p = 0; p < 2; p++) begin
      st_d.path[p] = st_q.acc[31:16] +
        {{6{trim[p][9]}}, trim[p]}; // [R9] [R10]
    end
  end

  // State register.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_phase = st_q.acc[31:16];
  assign o_i_phase = st_q.path[0];
  assign o_q_phase = st_q.path[1];

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_START_LOAD: assert property ( // [R4] [R6]
    i_load |=> o_phase == $past(i_start))
    else $error("Start phase not taken on oscillator reset.");

  AST_ACC_STEP: assert property ( // [R12]
    !i_load |=> st_q.acc == 32'($past(st_q.acc) + $past(i_tw)))
    else $error("Accumulator did not step by the tuning word.");

  AST_I_TRIM: assert property ( // [R9]
    ##1 o_i_phase == 16'($past(o_phase) +
      {{6{$past(i_i_trim[9])}}, $past(i_i_trim)}))
    else $error("I path phase trim wrong.");

  AST_Q_TRIM: assert property ( // [R10]
    ##1 o_q_phase == 16'($past(o_phase) +
      {{6{$past(i_q_trim[9])}}, $past(i_q_trim)}))
    else $error("Q path phase trim wrong.");

endmodule // nco_phase_gen

`default_nettype wire

// >>> rtl/nco_pkg.sv
/*
  Constants, register indices and the state type of the oscillator
  tuning and phase control bank.
  Assumes one 100 MHz clock and an APB slave with 32-bit data.
*/
// Contract
// (R1) The 32-bit tuning word sits in four byte registers, low byte at 0x30 and high byte at 0x33, all cleared at reset.
// (R2) Writing tuning bytes leaves the carrier alone; the active word loads only when update bit 0 rises from 0 to 1.
// (R3) After that load the block sets update bit 1 to report it.
// (R4) The 16-bit start phase in two byte registers becomes the carrier phase whenever the oscillator is reset.
// (R5) The start phase is a signed value over one full turn, one step being about 0.0055 degrees.
// (R6) The start phase is decoded as two's complement, not as an unsigned magnitude.
// (R7) A rise of update bit 4 arms an oscillator reset on the first extended frame strobe after it.
// (R8) When that reset happens update bit 5 is set as acknowledge; it is 0 after reset.
// (R9) A 10-bit I-path trim at 0x38 and 0x39 bits 1:0 offsets the I phase against Q.
// (R10) A 10-bit Q-path trim at 0x3A and 0x3B bits 1:0 offsets the Q phase against I.
// (R11) Software writes all four tuning bytes before raising update bit 0.
// (R12) The accumulator adds the active tuning word each cycle and wraps modulo two to the 32.
// (R13) An acknowledge stays set until software writes its request bit to 0, which re-arms it.

package nco_pkg;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [7:0] NCO_IDX_TW0 = 8'h30;
  localparam logic [7:0] NCO_IDX_TW1 = 8'h31;
  localparam logic [7:0] NCO_IDX_TW2 = 8'h32;
  localparam logic [7:0] NCO_IDX_TW3 = 8'h33;
  localparam logic [7:0] NCO_IDX_PH_LO = 8'h34;
  localparam logic [7:0] NCO_IDX_PH_HI = 8'h35;
  localparam logic [7:0] NCO_IDX_CTRL = 8'h36;
  localparam logic [7:0] NCO_IDX_ITRIM_LO = 8'h38;
  localparam logic [7:0] NCO_IDX_ITRIM_HI = 8'h39;
  localparam logic [7:0] NCO_IDX_QTRIM_LO = 8'h3a;
  localparam logic [7:0] NCO_IDX_QTRIM_HI = 8'h3b;
  localparam logic [7:0] NCO_IDX_STAT = 8'h40;
  localparam logic [7:0] NCO_IDX_MASK = 8'h41;

  // ---------------------------------------------------------------
  // Update register fields and interrupt bits.
  // ---------------------------------------------------------------
  localparam int NCO_LOAD_REQ_BIT = 0;
  localparam int NCO_LOAD_ACK_BIT = 1;
  localparam int NCO_STRB_REQ_BIT = 4;
  localparam int NCO_STRB_ACK_BIT = 5;
  localparam int NCO_IRQ_LOAD_BIT = 0;
  localparam int NCO_IRQ_STRB_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and counts.
  // ---------------------------------------------------------------
  localparam logic [31:0] NCO_TW_RST = 32'h0000_0000;
  localparam logic [15:0] NCO_PHASE_RST = 16'h0000;
  localparam logic [9:0] NCO_TRIM_RST = 10'h000;
  localparam logic [1:0] NCO_IRQ_RST = 2'h0;
  localparam logic [3:0] NCO_FRAME_EXT_CYCLES = 4'h4;

  // One clocked copy of all top-level state.
  typedef struct packed {
    logic [31:0] tw_shadow;
    logic [31:0] tw_active;
    logic [15:0] start_phase;
    logic [9:0] i_trim;
    logic [9:0] q_trim;
    logic load_req;
    logic load_ack;
    logic strb_req;
    logic strb_ack;
    logic strb_pend;
    logic osc_rst;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } nco_regs_type;

  // Word index of a byte address.
  function automatic logic [7:0] nco_reg_index(input logic [11:0] a);
    return a[9:2];
  endfunction

  // True when the address hits a register of this bank.
  function automatic logic nco_is_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[11:10] != 2'h0 || a[1:0] != 2'h0) return 1'b0;
    return (i >= NCO_IDX_TW0 && i <= NCO_IDX_CTRL) ||
      (i >= NCO_IDX_ITRIM_LO && i <= NCO_IDX_QTRIM_HI) ||
      i == NCO_IDX_STAT || i == NCO_IDX_MASK;
  endfunction

endpackage

// >>> verif/nco_ctrl_tb.sv
/*
  Self-checking testbench of the oscillator tuning and phase control
  bank, driving its APB port and frame strobe directly.
  Assumes one 100 MHz clock and an APB slave with one wait state.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;

  // ---------------------------------------------------------------
  // Stimulus and observation signals.
  // ---------------------------------------------------------------
  logic i_clk;
  logic i_sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frame;
  logic [31:0] tw_out;
  logic [15:0] ph_out;
  logic [15:0] iph_out;
  logic [15:0] qph_out;
  logic irq;
  int n_fail;
  int tests_run;

  // The block under test, every port connected.
  nco_ctrl_top u_dut (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_frame_strobe(frame),
    .o_tuning_word(tw_out),
    .o_carrier_phase(ph_out),
    .o_i_phase(iph_out),
    .o_q_phase(qph_out),
    .o_irq(irq)
  );

  // ---------------------------------------------------------------
  // Clock, reset and shared tasks.
  // ---------------------------------------------------------------
  // Free running clock of 10 ns period.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Prints the verdict and stops the run.
  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; pready is sampled at the rising edge ending it.
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write with the response discarded.
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, wd, r, e);
  endtask

  // Register read compared against the expected word.
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask

  // Holds the frame strobe high for four cycles, then lets it settle.
  task automatic frame_pulse();
    @(posedge i_clk);
    frame <= 1'b1;
    repeat (4) @(posedge i_clk);
    frame <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  // Every register of the map reads zero after reset.
  task automatic t_reset_values();
    logic [7:0] idx [13];
    idx = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
      8'h38, 8'h39, 8'h3a, 8'h3b, 8'h40, 8'h41};
    foreach (idx[k]) rd_chk(idx[k], 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // Shadow bytes stay inactive until the load request edge.
  task automatic t_word_load();
    logic [15:0] p0;
    wr(nco_pkg::NCO_IDX_TW0, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_TW1, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_TW2, 32'h0000_0001);
    wr(nco_pkg::NCO_IDX_TW3, 32'h0000_0000);
    repeat (3) @(negedge i_clk);
    chk(tw_out, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0001);
    repeat (2) @(negedge i_clk);
    chk(tw_out, 32'h0001_0000);
    p0 = ph_out;
    @(negedge i_clk);
    chk({16'h0, ph_out}, {16'h0, p0 + 16'h0001});
    rd_chk(nco_pkg::NCO_IDX_CTRL, 32'h0000_0003);
  endtask

  // Load event raises the interrupt only while unmasked.
  task automatic t_irq();
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(nco_pkg::NCO_IDX_STAT, 32'h0000_0001);
    wr(nco_pkg::NCO_IDX_MASK, 32'h0000_0001);
    repeat (2) @(negedge i_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(nco_pkg::NCO_IDX_STAT, 32'h0000_0001);
    repeat (2) @(negedge i_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(nco_pkg::NCO_IDX_MASK, 32'h0000_0001);
  endtask

  // A second load needs the request bit to drop first.
  task automatic t_rearm();
    wr(nco_pkg::NCO_IDX_TW2, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0001);
    repeat (2) @(negedge i_clk);
    chk(tw_out, 32'h0001_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0000);
    rd_chk(nco_pkg::NCO_IDX_CTRL, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0001);
    repeat (2) @(negedge i_clk);
    chk(tw_out, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0000);
  endtask

  // Frame strobe resets the phase only once armed.
  task automatic t_strobe_reset();
    logic [15:0] p0;
    wr(nco_pkg::NCO_IDX_STAT, 32'h0000_0001);
    wr(nco_pkg::NCO_IDX_PH_LO, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_PH_HI, 32'h0000_0080);
    p0 = ph_out;
    frame_pulse();
    chk({16'h0, ph_out}, {16'h0, p0});
    rd_chk(nco_pkg::NCO_IDX_CTRL, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0010);
    frame_pulse();
    chk({16'h0, ph_out}, 32'h0000_8000);
    rd_chk(nco_pkg::NCO_IDX_CTRL, 32'h0000_0030);
    rd_chk(nco_pkg::NCO_IDX_STAT, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(nco_pkg::NCO_IDX_CTRL, 32'h0000_0000);
    rd_chk(nco_pkg::NCO_IDX_CTRL, 32'h0000_0000);
  endtask

  // Signed trims offset the I and Q phases from the carrier.
  task automatic t_trims();
    wr(nco_pkg::NCO_IDX_ITRIM_LO, 32'h0000_00ff);
    wr(nco_pkg::NCO_IDX_ITRIM_HI, 32'h0000_0003);
    wr(nco_pkg::NCO_IDX_QTRIM_LO, 32'h0000_0001);
    wr(nco_pkg::NCO_IDX_QTRIM_HI, 32'h0000_0000);
    repeat (3) @(negedge i_clk);
    chk({16'h0, iph_out}, 32'h0000_7fff);
    chk({16'h0, qph_out}, 32'h0000_8001);
  endtask

  // An unmapped address answers with an error and zero data.
  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h37, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------
  // Reset for four cycles, then every scenario in turn.
  initial begin
    n_fail = 0;
    tests_run = 0;
    i_sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    frame = 1'b0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset_values();
    t_word_load();
    t_irq();
    t_rearm();
    t_strobe_reset();
    t_trims();
    t_unmapped();
    complete_run();
  end

  // Cuts a hang short well after the scenarios should have ended.
  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    complete_run();
  end

endmodule // testbench

`default_nettype wire
